// *** rtl/cond_check.sv ***
// Purpose: Evaluate the three-bit branch condition against the flag byte
// Assumes: Condition code taken from opcode bits 5 to 3
// Notes: Purely combinational
`timescale 1ns/1ps
module cond_check (
	input wire logic [2:0] cc,
	input wire logic [7:0] flags,
	output logic taken
);
	import exec_pkg::*;

	logic flag_sel;

	always_comb begin
		case (cc[2:1])
			2'b00: flag_sel = flags[FLAG_Z];
			2'b01: flag_sel = flags[FLAG_CY];
			2'b10: flag_sel = flags[FLAG_P];
			default: flag_sel = flags[FLAG_S];
		endcase
		taken = (flag_sel == cc[0]); // RULE_03
	end

endmodule // cond_check

// *** rtl/exec_core.sv ***
// Purpose: Execution core for jumps, calls, returns, restarts, stack, port I/O and mask ops
// Assumes: APB register access, external bus answers reads by the third state of a cycle
// Notes: One processor state per sys_clk; halt takes 5 states, undefined opcodes execute as 4-state no-ops
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Opcode first, then low byte, then high
// (RULE_02) First byte alone selects the operation
// (RULE_03) Conditional jump: 10 states taken, 7 not
// (RULE_04) Conditional call pushes return address, 18/9 states
// (RULE_05) Conditional return pops counter, 12/6 states
// (RULE_06) Restart pushes, jumps to n times 8
// (RULE_07) Pop low then high, pointer plus two
// (RULE_08) Flag byte S Z 0 AC 0 P 0 CY
// (RULE_09) Port input reads accumulator in 10 states
// (RULE_10) Port output writes accumulator in 10 states
// (RULE_11) Mask read loads masks, pending, serial pin
// (RULE_12) Mask set updates masks from accumulator
// (RULE_13) Serial enable loads serial output latch
// (RULE_14) Edge request pending until serviced or cleared
// (RULE_15) Enable/disable interrupt flop; halt after 5
// (RULE_16) Undefined opcodes leave state untouched
module exec_core (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output exec_pkg::bus_req_t bus,
	input wire logic [7:0] bus_din,
	input wire logic serial_in_pin,
	input wire logic rst75_pin,
	input wire logic rst65_pin,
	input wire logic rst55_pin,
	input wire logic hi_restart_ack,
	output logic serial_out_latch,
	output logic irq_enable_flop
);
	import exec_pkg::*;

	typedef enum {
		S_IDLE, S_FETCH, S_LO, S_HI, S_PUSH_HI, S_PUSH_LO, S_POP_LO, S_POP_HI, S_IO, S_HALT_T, S_HALTED
	} state_t;

	state_t state;
	state_t next_state;
	state_t after_op;
	logic [2:0] tcnt;
	logic [2:0] last_t;
	logic done;
	logic read_edge;
	logic [7:0] op;
	op_class_t cls;
	logic cond_true;
	logic run;
	logic [15:0] pc;
	logic [15:0] sp;
	logic [7:0] a, f, b, c, d, e, h, l;
	logic [7:0] tmp_lo;
	logic [7:0] tmp_hi;
	logic [7:0] rim_byte;
	logic sim_stb;
	logic apb_wr;
	logic [15:0] push_word;
	bus_req_t next_bus;
	logic [31:0] next_prdata;
	logic next_err;

	assign cls = decode_op(op); // RULE_02
	assign sim_stb = (state == S_FETCH) && done && (cls == OP_SIM);
	assign read_edge = (tcnt == T_READ_AT);
	assign apb_wr = psel && penable && pwrite && pready && (state == S_IDLE);

	cond_check u_cond (
		.cc(op[5:3]),
		.flags(f),
		.taken(cond_true)
	);

	mask_unit u_mask (
		.sys_clk(sys_clk),
		.rst(rst),
		.sim_stb(sim_stb),
		.acc(a),
		.rst75_pin(rst75_pin),
		.rst65_pin(rst65_pin),
		.rst55_pin(rst55_pin),
		.hi_restart_ack(hi_restart_ack),
		.serial_in_pin(serial_in_pin),
		.irq_enable_flop(irq_enable_flop),
		.rim_byte(rim_byte),
		.serial_out_latch(serial_out_latch)
	);

	// State counts come from cycle lengths: fetch 4 or 6, each bus cycle 3
	always_comb begin
		case (state)
			S_FETCH: last_t = fetch_is_long(cls) ? T_FETCH6_LAST : T_FETCH4_LAST;
			S_LO, S_HI, S_PUSH_HI, S_PUSH_LO, S_POP_LO, S_POP_HI, S_IO: last_t = T_BUS_LAST;
			default: last_t = T_HALT_LAST;
		endcase
		done = (tcnt == last_t);
	end

	always_comb begin
		after_op = run ? S_FETCH : S_IDLE;
		next_state = state;
		if (done) begin
			case (state)
				S_IDLE: next_state = run ? S_FETCH : S_IDLE;
				S_FETCH: begin
					case (cls)
						OP_JMP, OP_JCC, OP_CALL, OP_CCC, OP_IN, OP_OUT: next_state = S_LO; // RULE_01
						OP_RET, OP_POP: next_state = S_POP_LO; // RULE_07
						OP_RCC: next_state = cond_true ? S_POP_LO : after_op; // RULE_05
						OP_RST, OP_PUSH: next_state = S_PUSH_HI; // RULE_06
						OP_HALT: next_state = S_HALT_T; // RULE_15
						default: next_state = after_op; // RULE_16
					endcase
				end
				S_LO: begin
					if ((cls == OP_JCC || cls == OP_CCC) && !cond_true) begin
						next_state = after_op; // RULE_03
					end else if (cls == OP_IN || cls == OP_OUT) begin
						next_state = S_IO;
					end else begin
						next_state = S_HI;
					end
				end
				S_HI: next_state = (cls == OP_CALL || cls == OP_CCC) ? S_PUSH_HI : after_op; // RULE_04
				S_PUSH_HI: next_state = S_PUSH_LO;
				S_POP_LO: next_state = S_POP_HI;
				S_PUSH_LO, S_POP_HI, S_IO: next_state = after_op;
				S_HALT_T: next_state = S_HALTED;
				S_HALTED: next_state = run ? S_HALTED : S_IDLE;
				default: next_state = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= S_IDLE;
			tcnt <= 3'd0;
		end else begin
			state <= next_state;
			tcnt <= done ? 3'd0 : tcnt + 3'd1;
		end
	end

	// Word pushed: return address for calls and restarts, else the pair
	always_comb begin
		case (op[5:4])
			2'b00: push_word = {b, c};
			2'b01: push_word = {d, e};
			2'b10: push_word = {h, l};
			default: push_word = {a, flag_pack(f)}; // RULE_08
		endcase
		if (cls != OP_PUSH) begin
			push_word = pc; // RULE_04 RULE_06
		end
	end

	// Bus request registered at state 0 of each machine cycle
	always_comb begin
		next_bus = '0;
		next_bus.stb = 1'b1;
		case (state)
			S_FETCH, S_LO, S_HI: begin
				next_bus.addr = pc;
				next_bus.rd = 1'b1;
			end
			S_PUSH_HI: begin
				next_bus.addr = sp - 16'h0001; // RULE_04
				next_bus.dout = push_word[15:8];
				next_bus.wr = 1'b1;
			end
			S_PUSH_LO: begin
				next_bus.addr = sp - 16'h0002; // RULE_04
				next_bus.dout = push_word[7:0];
				next_bus.wr = 1'b1;
			end
			S_POP_LO: begin
				next_bus.addr = sp; // RULE_05 RULE_07
				next_bus.rd = 1'b1;
			end
			S_POP_HI: begin
				next_bus.addr = sp + 16'h0001; // RULE_05 RULE_07
				next_bus.rd = 1'b1;
			end
			S_IO: begin
				next_bus.addr = {tmp_lo, tmp_lo}; // RULE_09 RULE_10
				next_bus.io = 1'b1;
				next_bus.rd = (cls == OP_IN); // RULE_09
				next_bus.wr = (cls == OP_OUT); // RULE_10
				next_bus.dout = (cls == OP_OUT) ? a : 8'h00; // RULE_10
			end
			default: next_bus = '0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus <= '0;
		end else if (tcnt == T_STROBE_AT) begin
			bus <= next_bus;
		end else begin
			bus.stb <= 1'b0;
		end
	end

	// Architectural state and APB preload
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc <= RST_PC;
			sp <= RST_SP;
			{a, f, b, c, d, e, h, l} <= '0;
			op <= 8'h00;
			tmp_lo <= 8'h00;
			tmp_hi <= 8'h00;
			irq_enable_flop <= 1'b0;
		end else if (apb_wr) begin
			if (paddr == OFS_PC) begin
				pc <= pwdata[15:0];
			end else if (paddr == OFS_SP) begin
				sp <= pwdata[15:0];
			end else if (paddr == OFS_AF) begin
				a <= pwdata[15:8];
				f <= flag_pack(pwdata[7:0]); // RULE_08
			end else if (paddr == OFS_BC) begin
				{b, c} <= pwdata[15:0];
			end else if (paddr == OFS_DE) begin
				{d, e} <= pwdata[15:0];
			end else if (paddr == OFS_HL) begin
				{h, l} <= pwdata[15:0];
			end
		end else begin
			case (state)
				S_FETCH: begin
					if (read_edge) begin
						op <= bus_din;
						pc <= pc + 16'h0001;
					end
					if (done) begin
						case (cls)
							OP_IRQ_ON: irq_enable_flop <= 1'b1; // RULE_15
							OP_IRQ_OFF: irq_enable_flop <= 1'b0; // RULE_15
							OP_READ_MASK: a <= rim_byte; // RULE_11
							OP_JUMP_PAIR: pc <= {h, l};
							default: ;
						endcase
					end
				end
				S_LO: begin
					if (read_edge) begin
						tmp_lo <= bus_din; // RULE_01
						if ((cls == OP_JCC || cls == OP_CCC) && !cond_true) begin
							pc <= pc + 16'h0002; // RULE_03 RULE_04
						end else begin
							pc <= pc + 16'h0001;
						end
					end
				end
				S_HI: begin
					if (read_edge) begin
						tmp_hi <= bus_din; // RULE_01
						pc <= (cls == OP_JMP || cls == OP_JCC) ? {bus_din, tmp_lo} : pc + 16'h0001; // RULE_03
					end
				end
				S_PUSH_LO: begin
					if (done) begin
						sp <= sp - 16'h0002; // RULE_04 RULE_06
						if (cls == OP_CALL || cls == OP_CCC) begin
							pc <= {tmp_hi, tmp_lo}; // RULE_04
						end else if (cls == OP_RST) begin
							pc <= {10'h000, op[5:3], 3'b000}; // RULE_06
						end
					end
				end
				S_POP_LO: begin
					if (read_edge) begin
						tmp_lo <= bus_din;
					end
				end
				S_POP_HI: begin
					if (read_edge) begin
						sp <= sp + 16'h0002; // RULE_05 RULE_07
						if (cls == OP_POP) begin
							case (op[5:4])
								2'b00: {b, c} <= {bus_din, tmp_lo}; // RULE_07
								2'b01: {d, e} <= {bus_din, tmp_lo};
								2'b10: {h, l} <= {bus_din, tmp_lo};
								default: {a, f} <= {bus_din, flag_pack(tmp_lo)}; // RULE_08
							endcase
						end else begin
							pc <= {bus_din, tmp_lo}; // RULE_05
						end
					end
				end
				S_IO: begin
					if (read_edge && cls == OP_IN) begin
						a <= bus_din; // RULE_09
					end
				end
				default: ;
			endcase
		end
	end

	// Run control; clearing run stops after the current instruction
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run <= 1'b0;
		end else if (psel && penable && pwrite && pready && paddr == OFS_CTRL) begin
			run <= pwdata[CTRL_RUN_BIT];
		end
	end

	// One wait state so read data can come from a flop
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_err = 1'b0;
		if (paddr == OFS_CTRL) begin
			next_prdata[CTRL_RUN_BIT] = run;
		end else if (paddr == OFS_STATUS) begin
			next_prdata[STAT_HALT_BIT] = (state == S_HALTED);
			next_prdata[STAT_BUSY_BIT] = (state != S_IDLE);
			next_prdata[STAT_IE_BIT] = irq_enable_flop;
		end else if (paddr == OFS_PC) begin
			next_prdata[15:0] = pc;
		end else if (paddr == OFS_SP) begin
			next_prdata[15:0] = sp;
		end else if (paddr == OFS_AF) begin
			next_prdata[15:0] = {a, flag_pack(f)};
		end else if (paddr == OFS_BC) begin
			next_prdata[15:0] = {b, c};
		end else if (paddr == OFS_DE) begin
			next_prdata[15:0] = {d, e};
		end else if (paddr == OFS_HL) begin
			next_prdata[15:0] = {h, l};
		end else if (paddr == OFS_MASK) begin
			next_prdata[7:0] = rim_byte;
		end else if (paddr == OFS_OPCODE) begin
			next_prdata[7:0] = op;
		end else begin
			next_err = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && next_err;
			prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

endmodule // exec_core

// *** rtl/exec_pkg.sv ***
// Purpose: Shared constants, types and decode for the control-transfer execution core
// Assumes: One clock at 100 MHz, one processor state per clock
// Notes: Flag byte layout, cycle lengths and opcode classes live here
package exec_pkg;

	// Machine-cycle lengths, counted as last state index, then the strobe and read state indexes
	localparam logic [2:0] T_BUS_LAST = 3'd2;
	localparam logic [2:0] T_FETCH4_LAST = 3'd3;
	localparam logic [2:0] T_FETCH6_LAST = 3'd5;
	localparam logic [2:0] T_HALT_LAST = 3'd0;
	localparam logic [2:0] T_READ_AT = 3'd2;
	localparam logic [2:0] T_STROBE_AT = 3'd0;

	// Register offsets on the APB side
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PC = 8'h08;
	localparam logic [7:0] OFS_SP = 8'h0c;
	localparam logic [7:0] OFS_AF = 8'h10;
	localparam logic [7:0] OFS_BC = 8'h14;
	localparam logic [7:0] OFS_DE = 8'h18;
	localparam logic [7:0] OFS_HL = 8'h1c;
	localparam logic [7:0] OFS_MASK = 8'h20;
	localparam logic [7:0] OFS_OPCODE = 8'h24;

	// Field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_HALT_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_IE_BIT = 2;
	localparam logic [7:0] FLAG_USED = 8'hd5;
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_P = 2;
	localparam int FLAG_CY = 0;
	localparam int SIM_MASK_EN = 3;
	localparam int SIM_CLR_HI = 4;
	localparam int SIM_SER_EN = 6;
	localparam int SIM_SER_BIT = 7;

	// Reset values
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [15:0] RST_SP = 16'h0000;
	localparam logic [2:0] RST_MASKS = 3'h7;

	typedef enum {
		OP_NOP, OP_JMP, OP_JCC, OP_CALL, OP_CCC, OP_RET, OP_RCC, OP_RST, OP_PUSH, OP_POP,
		OP_IN, OP_OUT, OP_IRQ_ON, OP_IRQ_OFF, OP_READ_MASK, OP_SIM, OP_HALT, OP_JUMP_PAIR, OP_UNDEF
	} op_class_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dout;
		logic rd;
		logic wr;
		logic io;
		logic stb;
	} bus_req_t;

	// Class from the first byte alone: high nibble row, low nibble column
	function automatic op_class_t decode_op(input logic [7:0] op);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		decode_op = OP_UNDEF;
		if (hi >= 4'hc) begin
			case (lo)
				4'h0, 4'h8: decode_op = OP_RCC;
				4'h1: decode_op = OP_POP;
				4'h2, 4'ha: decode_op = OP_JCC;
				4'h4, 4'hc: decode_op = OP_CCC;
				4'h5: decode_op = OP_PUSH;
				4'h7, 4'hf: decode_op = OP_RST;
				4'h3: decode_op = (hi == 4'hc) ? OP_JMP : (hi == 4'hd) ? OP_OUT : (hi == 4'hf) ? OP_IRQ_OFF : OP_UNDEF;
				4'hb: decode_op = (hi == 4'hd) ? OP_IN : (hi == 4'hf) ? OP_IRQ_ON : OP_UNDEF;
				4'h9: decode_op = (hi == 4'hc) ? OP_RET : (hi == 4'he) ? OP_JUMP_PAIR : OP_UNDEF;
				4'hd: decode_op = (hi == 4'hc) ? OP_CALL : OP_UNDEF;
				default: decode_op = OP_UNDEF;
			endcase
		end else if (op == 8'h00) begin
			decode_op = OP_NOP;
		end else if (op == 8'h20) begin
			decode_op = OP_READ_MASK;
		end else if (op == 8'h30) begin
			decode_op = OP_SIM;
		end else if (op == 8'h76) begin
			decode_op = OP_HALT;
		end
	endfunction

	function automatic logic fetch_is_long(input op_class_t c);
		fetch_is_long = (c == OP_CALL) || (c == OP_CCC) || (c == OP_RCC) || (c == OP_RST) ||
			(c == OP_PUSH) || (c == OP_JUMP_PAIR);
	endfunction

	// Unused flag positions always read zero
	function automatic logic [7:0] flag_pack(input logic [7:0] f);
		flag_pack = f & FLAG_USED;
	endfunction

endpackage

// *** rtl/mask_unit.sv ***
// Purpose: Restart masks, latched edge request, serial output latch and mask-read byte
// Assumes: Pins synchronous to sys_clk
// Notes: Set of the edge request wins over any clear in the same cycle
`timescale 1ns/1ps
module mask_unit (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sim_stb,
	input wire logic [7:0] acc,
	input wire logic rst75_pin,
	input wire logic rst65_pin,
	input wire logic rst55_pin,
	input wire logic hi_restart_ack,
	input wire logic serial_in_pin,
	input wire logic irq_enable_flop,
	output logic [7:0] rim_byte,
	output logic serial_out_latch
);
	import exec_pkg::*;

	logic [2:0] masks;
	logic pend75;
	logic pin75_prev;
	logic rise75;

	assign rise75 = rst75_pin & ~pin75_prev;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin75_prev <= 1'b0;
		end else begin
			pin75_prev <= rst75_pin;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend75 <= 1'b0;
		end else if (rise75) begin
			pend75 <= 1'b1; // RULE_14
		end else if (hi_restart_ack || (sim_stb && acc[SIM_CLR_HI])) begin
			pend75 <= 1'b0; // RULE_14
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			masks <= RST_MASKS;
		end else if (sim_stb && acc[SIM_MASK_EN]) begin
			masks <= acc[2:0]; // RULE_12
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serial_out_latch <= 1'b0;
		end else if (sim_stb && acc[SIM_SER_EN]) begin
			serial_out_latch <= acc[SIM_SER_BIT]; // RULE_13
		end
	end

	// Read view: serial pin, pending requests, enable, masks
	assign rim_byte = {serial_in_pin, pend75, rst65_pin, rst55_pin, irq_enable_flop, masks}; // RULE_11

endmodule // mask_unit

// *** testbench/bus_mem_model.sv ***
// Purpose: Memory and port devices on the processor bus
// Assumes: Read data due one cycle after the strobe
// Notes: Ports answer with the inverted port number
`timescale 1ns/1ps
module bus_mem_model (
	input wire logic sys_clk,
	input wire exec_pkg::bus_req_t bus,
	output logic [7:0] bus_din
);
	logic [7:0] mem [0:65535];
	logic [7:0] out_port = 8'h00;
	logic [7:0] out_data = 8'h00;
	initial bus_din = 8'h00;
	always @(posedge sys_clk) begin
		if (bus.stb && bus.rd)
			bus_din <= bus.io ? ~bus.addr[7:0] : mem[bus.addr];
		else
			bus_din <= ~bus_din; // Released bus: never a stale match
		if (bus.stb && bus.wr && bus.io) begin
			out_port <= bus.addr[7:0];
			out_data <= bus.dout;
		end
		if (bus.stb && bus.wr && !bus.io)
			mem[bus.addr] <= bus.dout;
	end
endmodule // bus_mem_model

// *** testbench/exec_core_asserts.sv ***
// Purpose: Port-level checks of the execution core
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound onto every exec_core instance
`timescale 1ns/1ps
module exec_core_asserts import exec_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire exec_pkg::bus_req_t bus,
	input wire logic serial_out_latch,
	input wire logic irq_enable_flop
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_ready_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata nonzero outside answer");
	a_strobe_spacing: assert property (bus.stb |=> !bus.stb [*2])
		else $error("machine cycle shorter than three states");
	a_bus_stands: assert property (bus.stb |=> ($stable(bus.addr) && $stable(bus.wr)) [*2])
		else $error("bus request moved inside machine cycle");
	a_port_mirror: assert property (bus.stb && bus.io |-> bus.addr[15:8] == bus.addr[7:0])
		else $error("port number not on both address halves");
	a_io_direction: assert property (bus.stb && bus.io |-> bus.rd ^ bus.wr)
		else $error("port cycle with bad direction");
	a_push_descend: assert property ((bus.stb && bus.wr && !bus.io) ##3 (bus.stb && bus.wr)
		|-> bus.addr == $past(bus.addr, 3) - 16'h1)
		else $error("stack writes not descending");
	a_release_quiet: assert property ($fell(rst) |-> !pready && (bus == '0) && !irq_enable_flop && !serial_out_latch)
		else $error("outputs not quiet after reset");
endmodule // exec_core_asserts
bind exec_core exec_core_asserts exec_core_asserts_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus),
	.serial_out_latch(serial_out_latch), .irq_enable_flop(irq_enable_flop));

// *** testbench/exec_core_test.sv ***
// Purpose: Self-checking bench of the execution core
// Assumes: Program at 100, halt at 101 to 103, 300 and 38, stack at 2000
// Notes: State count is the gap between first and last bus strobe
`timescale 1ns/1ps
module exec_core_test;
	import exec_pkg::*;
	typedef struct {logic [7:0] op, b1, b2; logic [15:0] af, pc, sp, stk; logic [7:0] ofs; logic [31:0] val; int st;} row_t;
	logic sys_clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, serial_out_latch, irq_enable_flop;
	bus_req_t bus;
	logic [7:0] bus_din;
	logic serial_in_pin = 1;
	logic rst75_pin = 0;
	logic rst65_pin = 1;
	logic rst55_pin = 0;
	logic hi_restart_ack = 0;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int first, last;
	logic [31:0] d;
	logic e;
	row_t rows [0:18] = '{
		'{8'hc3, 8'h00, 8'h03, 16'h0, 16'h301, 16'h2000, 16'h0, OFS_AF, 32'h0, 10},
		'{8'hca, 8'h00, 8'h03, 16'h40, 16'h301, 16'h2000, 16'h0, OFS_AF, 32'h40, 10},
		'{8'hca, 8'h00, 8'h03, 16'h0, 16'h104, 16'h2000, 16'h0, OFS_AF, 32'h0, 7},
		'{8'hfa, 8'h00, 8'h03, 16'h80, 16'h301, 16'h2000, 16'h0, OFS_AF, 32'h80, 10},
		'{8'he2, 8'h00, 8'h03, 16'h4, 16'h104, 16'h2000, 16'h0, OFS_AF, 32'h4, 7},
		'{8'hdc, 8'h00, 8'h03, 16'h1, 16'h301, 16'h1ffe, 16'h103, OFS_AF, 32'h1, 18},
		'{8'hd4, 8'h00, 8'h03, 16'h1, 16'h104, 16'h2000, 16'h0, OFS_AF, 32'h1, 9},
		'{8'hc8, 8'h76, 8'h00, 16'h40, 16'h301, 16'h2002, 16'h0, OFS_AF, 32'h40, 12},
		'{8'hc0, 8'h76, 8'h00, 16'h40, 16'h102, 16'h2000, 16'h0, OFS_AF, 32'h40, 6},
		'{8'hff, 8'h76, 8'h00, 16'h0, 16'h39, 16'h1ffe, 16'h101, OFS_AF, 32'h0, 12},
		'{8'hc1, 8'h76, 8'h00, 16'h0, 16'h102, 16'h2002, 16'h0, OFS_BC, 32'h300, 10},
		'{8'hf5, 8'h76, 8'h00, 16'h5aff, 16'h102, 16'h1ffe, 16'h5ad5, OFS_AF, 32'h5ad5, 12},
		'{8'hdb, 8'h40, 8'h76, 16'h11, 16'h103, 16'h2000, 16'h0, OFS_AF, 32'hbf11, 10},
		'{8'h20, 8'h76, 8'h00, 16'h0, 16'h102, 16'h2000, 16'h0, OFS_AF, 32'ha700, 4},
		'{8'h30, 8'h76, 8'h00, 16'hca00, 16'h102, 16'h2000, 16'h0, OFS_MASK, 32'ha2, 4},
		'{8'hfb, 8'h76, 8'h00, 16'h0, 16'h102, 16'h2000, 16'h0, OFS_STATUS, 32'h7, 4},
		'{8'hf3, 8'h76, 8'h00, 16'h0, 16'h102, 16'h2000, 16'h0, OFS_STATUS, 32'h3, 4},
		'{8'hcb, 8'h76, 8'h00, 16'h1234, 16'h102, 16'h2000, 16'h0, OFS_AF, 32'h1214, 4},
		'{8'hd3, 8'h41, 8'h76, 16'h6600, 16'h103, 16'h2000, 16'h0, OFS_AF, 32'h6600, 10}
	};

	exec_core exec_core_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus),
		.bus_din(bus_din), .serial_in_pin(serial_in_pin), .rst75_pin(rst75_pin), .rst65_pin(rst65_pin),
		.rst55_pin(rst55_pin), .hi_restart_ack(hi_restart_ack), .serial_out_latch(serial_out_latch),
		.irq_enable_flop(irq_enable_flop));
	bus_mem_model bus_mem_model_inst (.sys_clk(sys_clk), .bus(bus), .bus_din(bus_din));

	initial forever #5 sys_clk = ~sys_clk;
	// Sampled off the edge so registered strobes are settled
	always @(negedge sys_clk) begin
		if (bus.stb === 1'b1) begin
			if (first < 0)
				first = cyc;
			last = cyc;
		end
		cyc++;
	end

	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r, output logic er);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		@(posedge sys_clk);
		// Answer taken only at the rising edge where pready is seen high
		while (pready !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 50) begin
			fails++;
			summarize();
		end
		r = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic run_row(input row_t r);
		int n;
		apb(1, OFS_CTRL, 32'h0, d, e);
		bus_mem_model_inst.mem[16'h100] = r.op;
		bus_mem_model_inst.mem[16'h101] = r.b1;
		bus_mem_model_inst.mem[16'h102] = r.b2;
		apb(1, OFS_PC, 32'h100, d, e);
		apb(1, OFS_SP, 32'h2000, d, e);
		apb(1, OFS_AF, {16'h0, r.af}, d, e);
		first = -1;
		apb(1, OFS_CTRL, 32'h1, d, e);
		n = 0;
		d = 32'h0;
		while (d[STAT_HALT_BIT] !== 1'b1 && n < 100) begin
			apb(0, OFS_STATUS, 32'h0, d, e);
			n++;
		end
		if (n >= 100) begin
			fails++;
			summarize();
		end
		apb(0, OFS_PC, 32'h0, d, e);
		chk(d, {16'h0, r.pc}, "pc");
		apb(0, OFS_SP, 32'h0, d, e);
		chk(d, {16'h0, r.sp}, "sp");
		apb(0, r.ofs, 32'h0, d, e);
		chk(d, r.val, "register");
		chk(last - first, r.st, "states");
		if (r.sp == 16'h1ffe)
			chk({16'h0, bus_mem_model_inst.mem[16'h1fff], bus_mem_model_inst.mem[16'h1ffe]}, {16'h0, r.stk}, "stack");
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 0;
		for (int i = 0; i < 65536; i++)
			bus_mem_model_inst.mem[i] = 8'h00;
		bus_mem_model_inst.mem[16'h103] = 8'h76;
		bus_mem_model_inst.mem[16'h300] = 8'h76;
		bus_mem_model_inst.mem[16'h38] = 8'h76;
		bus_mem_model_inst.mem[16'h2001] = 8'h03;
		apb(0, OFS_SP, 32'h0, d, e);
		chk(d, 32'h0, "sp after reset");
		apb(0, OFS_MASK, 32'h0, d, e);
		chk(d, 32'ha7, "mask after reset");
		foreach (rows[i])
			run_row(rows[i]);
		chk({24'h0, bus_mem_model_inst.out_port}, 32'h41, "port");
		chk({24'h0, bus_mem_model_inst.out_data}, 32'h66, "port data");
		chk({31'h0, serial_out_latch}, 32'h1, "serial out");
		chk({31'h0, irq_enable_flop}, 32'h0, "irq enable");
		apb(0, 8'hfc, 32'h0, d, e);
		chk({e, d[30:0]}, 32'h80000000, "unmapped");
		@(posedge sys_clk);
		rst75_pin <= 1;
		apb(0, OFS_MASK, 32'h0, d, e);
		chk(d, 32'he2, "edge pending");
		apb(0, OFS_MASK, 32'h0, d, e);
		chk(d, 32'he2, "edge still pending");
		@(posedge sys_clk);
		hi_restart_ack <= 1;
		@(posedge sys_clk);
		hi_restart_ack <= 0;
		apb(0, OFS_MASK, 32'h0, d, e);
		chk(d, 32'ha2, "edge serviced");
		@(posedge sys_clk);
		rst75_pin <= 0;
		@(posedge sys_clk);
		rst75_pin <= 1;
		hi_restart_ack <= 1;
		@(posedge sys_clk);
		hi_restart_ack <= 0;
		apb(0, OFS_MASK, 32'h0, d, e);
		chk(d, 32'he2, "edge set beats service");
		run_row(row_t'{8'h30, 8'h76, 8'h00, 16'h1000, 16'h102, 16'h2000, 16'h0, OFS_MASK, 32'ha2, 4});
		summarize();
	end
endmodule // exec_core_test
